// >>> verilog/tsqr_responder.sv
// tsqr_responder: serial query responder of a 64-key matrix touch sensor,
// with per-key error flags and the forced recalibration retry engine.
// assumes key arrays come from the sensing core on core_clk and the host
// clocks 8 link_sclk edges per byte, data sampled on rising edges.
// Contract
// R1: status bits: detect, recalibrating, error
// R2: status bit3: external sync lock lost
// R3: status bit4: setup copies disagree
// R4: status upper three bits read zero
// R5: group signal: 8 or 64 bytes
// R6: group delta, clipped at zero
// R7: group reference, 8 or 64 bytes
// R8: group ladder offset, 8 or 64 bytes
// R9: group charge cancel state, 8/64
// R10: group integrator counts, 8 or 64
// R11: key error query returns four flags
// R12: five recalibration tries before fail flag
// R13: recalibration start clears high, low
// R14: high flag: drift above 191, window
// R15: low flag: drift below 64, window
// R16: group error: one byte per scope
// R17: matrix error: eight bytes, column first
// R18: first key number plus more bit
// R19: no key detecting returns all ones
// R20: dropped key replaced by another active
// R21: group touch: one or eight bytes
// R22: two-byte single key scope command
// R23: key equals row plus eight column
// R24: response bytes out one per transfer
// R25: host polls status before details
`timescale 1ns/1ps
module tsqr_responder (
  // core clock and reset
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  // serial link
  input  wire logic         link_sclk,
  input  wire logic         link_mosi,
  output logic              link_miso,
  // key state from the sensing core
  input  wire logic [63:0]  key_detect,
  input  wire logic [511:0] key_signal,
  input  wire logic [511:0] key_reference,
  input  wire logic [511:0] key_ladder_offset,
  input  wire logic [127:0] key_charge_cancel,
  input  wire logic [511:0] key_integrator,
  // device condition
  input  wire logic         ext_sync_mode,
  input  wire logic         ext_sync_locked,
  input  wire logic         setup_copy_mismatch,
  // forced recalibration
  input  wire logic         cal_request,
  input  wire logic [5:0]   cal_request_key,
  input  wire logic [7:0]   cal_upper_limit,
  input  wire logic [7:0]   cal_lower_limit,
  input  wire logic         cal_attempt_done,
  input  wire logic         cal_attempt_ok,
  output logic              cal_attempt,
  output logic [5:0]        cal_attempt_key
);

  tsqr_pkg::tsqr_core_s cs;
  tsqr_pkg::tsqr_core_s next_cs;
  tsqr_pkg::tsqr_link_s ls;
  tsqr_pkg::tsqr_link_s next_ls;

  function automatic logic [7:0] key_byte(input logic [511:0] arr,
                                          input logic [5:0]   key);
    key_byte = arr[{key, 3'b000} +: 8];
  endfunction

  // map a response index onto a key under the group scope
  function automatic logic [5:0] group_key(input tsqr_pkg::tsqr_scope_e sc,
                                           input logic [2:0] row,
                                           input logic [2:0] col,
                                           input logic [5:0] idx);
    case (sc)
      tsqr_pkg::sc_row: group_key = {idx[2:0], row}; // R23
      tsqr_pkg::sc_col: group_key = {col, idx[2:0]}; // R23
      default:          group_key = idx;
    endcase
  endfunction

  // one bitmap byte: row gives columns, column or matrix gives rows
  function automatic logic [7:0] map_byte(input logic [63:0] vec,
                                          input tsqr_pkg::tsqr_scope_e sc,
                                          input logic [2:0] row,
                                          input logic [2:0] col,
                                          input logic [5:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (sc)
      tsqr_pkg::sc_key: b = {7'h00, vec[{col, row}]};
      tsqr_pkg::sc_row: begin
        for (int n = 0; n < 8; n++) begin
          b[n] = vec[{n[2:0], row}]; // R16
        end
      end
      tsqr_pkg::sc_col: b = vec[{col, 3'b000} +: 8]; // R16
      default:          b = vec[{idx[2:0], 3'b000} +: 8]; // R17
    endcase
    map_byte = b;
  endfunction

  function automatic logic [5:0] lowest_key(input logic [63:0] vec);
    logic [5:0] k;
    k = 6'h00;
    for (int n = 63; n >= 0; n--) begin
      if (vec[n]) begin
        k = n[5:0];
      end
    end
    lowest_key = k;
  endfunction

  logic [63:0] err_any;
  logic [7:0]  status_byte;
  logic [5:0]  sel_key;
  logic [7:0]  first_byte;
  logic [63:0] others;

  always_comb begin
    err_any = cs.fail | cs.high | cs.low;
    sel_key = {cs.col, cs.row}; // R23
    status_byte = 8'h00; // R4
    status_byte[tsqr_pkg::ST_DETECT]   = |key_detect; // R1
    status_byte[tsqr_pkg::ST_RECAL]    = |cs.recal; // R1
    status_byte[tsqr_pkg::ST_ERROR]    = |err_any; // R1
    status_byte[tsqr_pkg::ST_SYNCLOST] = ext_sync_mode & ~ext_sync_locked; // R2
    status_byte[tsqr_pkg::ST_MISMATCH] = setup_copy_mismatch; // R3
  end

  // byte for a group response kind at a given index
  function automatic logic [7:0] group_byte(input tsqr_pkg::tsqr_kind_e k,
                                            input logic [5:0] key,
                                            input logic [7:0] emap,
                                            input logic [7:0] tmap);
    logic [7:0] sig;
    logic [7:0] ref_v;
    sig   = key_byte(key_signal, key);
    ref_v = key_byte(key_reference, key);
    case (k)
      tsqr_pkg::rk_signal: group_byte = sig; // R5
      tsqr_pkg::rk_delta:
        group_byte = (ref_v > sig) ? 8'(ref_v - sig) : 8'h00; // R6
      tsqr_pkg::rk_ref:    group_byte = ref_v; // R7
      tsqr_pkg::rk_offset: group_byte = key_byte(key_ladder_offset, key); // R8
      tsqr_pkg::rk_cancel:
        group_byte = {6'h00, key_charge_cancel[{key, 1'b0} +: 2]}; // R9
      tsqr_pkg::rk_integ:  group_byte = key_byte(key_integrator, key); // R10
      tsqr_pkg::rk_gerr:   group_byte = emap; // R16
      tsqr_pkg::rk_touch:  group_byte = tmap; // R21
      default:             group_byte = tsqr_pkg::IDLE_BYTE;
    endcase
  endfunction

  logic [7:0]          rx_byte_c;
  logic                rx_event;
  tsqr_pkg::tsqr_kind_e g_kind;
  logic [5:0]          g_idx;
  logic [7:0]          g_emap;
  logic [7:0]          g_tmap;
  logic [7:0]          g_byte;
  logic [7:0]          kerr;
  logic [6:0]          line_len;
  logic [6:0]          map_len;

  always_comb begin
    next_cs = cs;
    next_cs.cal_attempt = 1'b0;
    // rx toggle crosses in; the byte itself is stable for a whole byte time
    next_cs.rx_sync = {cs.rx_sync[0], ls.rx_tgl};
    next_cs.rx_seen = cs.rx_sync[1];
    rx_event  = cs.rx_sync[1] ^ cs.rx_seen;
    rx_byte_c = ls.rx_byte;

    // drift bounds, held off while the key recalibrates
    for (int k = 0; k < 64; k++) begin
      if (!cs.recal[k]) begin
        if (key_byte(key_reference, k[5:0]) > tsqr_pkg::DRIFT_HIGH_LIMIT) begin
          next_cs.high[k] = 1'b1; // R14
        end
        if (key_byte(key_reference, k[5:0]) < tsqr_pkg::DRIFT_LOW_LIMIT) begin
          next_cs.low[k] = 1'b1; // R15
        end
      end
    end

    // forced recalibration; a request while busy is dropped
    case (cs.cal)
      tsqr_pkg::cal_idle: begin
        if (cal_request) begin
          next_cs.cal_key = cal_request_key;
          next_cs.recal[cal_request_key] = 1'b1;
          next_cs.high[cal_request_key]  = 1'b0; // R13
          next_cs.low[cal_request_key]   = 1'b0; // R13
          next_cs.fail[cal_request_key]  = 1'b0;
          next_cs.tries = 3'h1;
          next_cs.cal_attempt = 1'b1;
          next_cs.cal = tsqr_pkg::cal_wait;
        end
      end
      tsqr_pkg::cal_wait: begin
        if (cal_attempt_done) begin
          if (cal_attempt_ok) begin
            next_cs.recal[cs.cal_key] = 1'b0;
            if (key_byte(key_reference, cs.cal_key) > cal_upper_limit) begin
              next_cs.high[cs.cal_key] = 1'b1; // R14
            end
            if (key_byte(key_reference, cs.cal_key) < cal_lower_limit) begin
              next_cs.low[cs.cal_key] = 1'b1; // R15
            end
            next_cs.cal = tsqr_pkg::cal_idle;
          end else if (cs.tries == tsqr_pkg::CAL_TRIES) begin
            next_cs.fail[cs.cal_key]  = 1'b1; // R12
            next_cs.recal[cs.cal_key] = 1'b0;
            next_cs.cal = tsqr_pkg::cal_idle;
          end else begin
            next_cs.tries = 3'(cs.tries + 3'h1); // R12
            next_cs.cal_attempt = 1'b1; // R12
          end
        end
      end
      default: next_cs.cal = tsqr_pkg::cal_idle;
    endcase

    // first touched key: keep it while it still detects
    if (cs.first_valid && key_detect[cs.first_key]) begin
      next_cs.first_key = cs.first_key; // R20
    end else if (|key_detect) begin
      next_cs.first_key   = lowest_key(key_detect); // R20
      next_cs.first_valid = 1'b1;
    end else begin
      next_cs.first_valid = 1'b0;
    end
    others = key_detect;
    others[next_cs.first_key] = 1'b0;
    if (next_cs.first_valid) begin
      first_byte = {2'b00, next_cs.first_key}; // R18
      first_byte[tsqr_pkg::FIRST_MORE_BIT] = |others; // R18
    end else begin
      first_byte = tsqr_pkg::FIRST_NONE; // R19
    end

    // command interpreter
    kerr = {4'h0, cs.low[sel_key], cs.high[sel_key], cs.recal[sel_key],
            cs.fail[sel_key]}; // R11
    line_len = (cs.scope == tsqr_pkg::sc_row || cs.scope == tsqr_pkg::sc_col)
               ? tsqr_pkg::LEN_LINE : tsqr_pkg::LEN_MATRIX; // R5
    map_len = (cs.scope == tsqr_pkg::sc_key || cs.scope == tsqr_pkg::sc_row ||
               cs.scope == tsqr_pkg::sc_col)
              ? tsqr_pkg::LEN_ONE : tsqr_pkg::LEN_LINE; // R21
    g_kind = cs.kind;
    g_idx  = 6'(cs.idx + 6'h01);
    if (rx_event && cs.owed == 7'h00 && !cs.arg_wait) begin
      g_idx = 6'h00;
      case (rx_byte_c)
        tsqr_pkg::CMD_GRP_SIGNAL: g_kind = tsqr_pkg::rk_signal;
        tsqr_pkg::CMD_GRP_DELTA:  g_kind = tsqr_pkg::rk_delta;
        tsqr_pkg::CMD_GRP_REF:    g_kind = tsqr_pkg::rk_ref;
        tsqr_pkg::CMD_GRP_OFFSET: g_kind = tsqr_pkg::rk_offset;
        tsqr_pkg::CMD_GRP_CANCEL: g_kind = tsqr_pkg::rk_cancel;
        tsqr_pkg::CMD_GRP_INTEG:  g_kind = tsqr_pkg::rk_integ;
        tsqr_pkg::CMD_GRP_ERR:    g_kind = tsqr_pkg::rk_gerr;
        tsqr_pkg::CMD_GRP_TOUCH:  g_kind = tsqr_pkg::rk_touch;
        default:                  g_kind = tsqr_pkg::rk_none;
      endcase
    end
    g_emap = (cs.scope == tsqr_pkg::sc_key) ? kerr :
             map_byte(err_any, cs.scope, cs.row, cs.col, g_idx); // R16
    g_tmap = map_byte(key_detect, cs.scope, cs.row, cs.col, g_idx); // R21
    g_byte = group_byte(g_kind,
                        group_key(cs.scope, cs.row, cs.col, g_idx),
                        g_emap, g_tmap);

    if (rx_event) begin
      if (cs.arg_wait) begin
        // second byte of a scope command, answered by the echo
        next_cs.arg_wait = 1'b0;
        case (cs.arg_cmd)
          tsqr_pkg::CMD_SCOPE_KEY: begin
            next_cs.scope = tsqr_pkg::sc_key; // R22
            next_cs.row   = rx_byte_c[2:0]; // R23
            next_cs.col   = rx_byte_c[5:3]; // R23
          end
          tsqr_pkg::CMD_SCOPE_ROW: begin
            next_cs.scope = tsqr_pkg::sc_row;
            next_cs.row   = rx_byte_c[2:0];
          end
          default: begin
            next_cs.scope = tsqr_pkg::sc_col;
            next_cs.col   = rx_byte_c[2:0];
          end
        endcase
        next_cs.tx_word = cs.arg_cmd;
        next_cs.owed    = tsqr_pkg::LEN_ONE;
        next_cs.kind    = tsqr_pkg::rk_none;
      end else if (cs.owed != 7'h00) begin
        // dummy byte: the host took one response byte
        next_cs.owed = 7'(cs.owed - 7'h01); // R24
        next_cs.idx  = g_idx;
        next_cs.tx_word = (cs.owed == tsqr_pkg::LEN_ONE) ?
                          tsqr_pkg::IDLE_BYTE : g_byte; // R24
      end else begin
        next_cs.kind    = g_kind;
        next_cs.idx     = 6'h00;
        next_cs.owed    = 7'h00;
        next_cs.tx_word = tsqr_pkg::IDLE_BYTE;
        case (rx_byte_c)
          tsqr_pkg::CMD_STATUS: begin
            next_cs.tx_word = status_byte; // R1
            next_cs.owed    = tsqr_pkg::LEN_ONE;
          end
          tsqr_pkg::CMD_GRP_SIGNAL, tsqr_pkg::CMD_GRP_DELTA,
          tsqr_pkg::CMD_GRP_REF, tsqr_pkg::CMD_GRP_OFFSET,
          tsqr_pkg::CMD_GRP_CANCEL, tsqr_pkg::CMD_GRP_INTEG: begin
            next_cs.tx_word = g_byte;
            next_cs.owed    = line_len; // R5
          end
          tsqr_pkg::CMD_GRP_ERR, tsqr_pkg::CMD_GRP_TOUCH: begin
            next_cs.tx_word = g_byte;
            next_cs.owed    = map_len; // R17
          end
          tsqr_pkg::CMD_KEY_ERR: begin
            next_cs.tx_word = kerr; // R11
            next_cs.owed    = tsqr_pkg::LEN_ONE;
          end
          tsqr_pkg::CMD_FIRST_KEY: begin
            next_cs.tx_word = first_byte; // R18
            next_cs.owed    = tsqr_pkg::LEN_ONE;
          end
          tsqr_pkg::CMD_SCOPE_ALL: begin
            next_cs.scope   = tsqr_pkg::sc_all;
            next_cs.tx_word = tsqr_pkg::CMD_SCOPE_ALL;
            next_cs.owed    = tsqr_pkg::LEN_ONE;
          end
          tsqr_pkg::CMD_SCOPE_KEY, tsqr_pkg::CMD_SCOPE_ROW,
          tsqr_pkg::CMD_SCOPE_COL: begin
            next_cs.arg_wait = 1'b1; // R22
            next_cs.arg_cmd  = rx_byte_c;
          end
          default: next_cs.owed = 7'h00;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cs <= '0;
      cs.scope   <= tsqr_pkg::sc_none;
      cs.row     <= tsqr_pkg::LINE_RST;
      cs.col     <= tsqr_pkg::LINE_RST;
      cs.kind    <= tsqr_pkg::rk_none;
      cs.tx_word <= tsqr_pkg::IDLE_BYTE;
      cs.cal     <= tsqr_pkg::cal_idle;
    end else begin
      cs <= next_cs;
    end
  end

  assign cal_attempt     = cs.cal_attempt;
  assign cal_attempt_key = cs.cal_key;

  // link side: tx_word is read at bit 0 only; the core updates it within a
  // few core cycles of a byte end, long before the next byte starts
  always_comb begin
    next_ls = ls;
    next_ls.rst_sync = {ls.rst_sync[0], sys_rst};
    next_ls.rx_shift = {ls.rx_shift[5:0], link_mosi};
    next_ls.bitcnt   = 3'(ls.bitcnt + 3'h1);
    if (ls.bitcnt == 3'h0) begin
      next_ls.miso     = cs.tx_word[7]; // R24
      next_ls.tx_shift = cs.tx_word[6:0];
    end else begin
      next_ls.miso     = ls.tx_shift[6];
      next_ls.tx_shift = {ls.tx_shift[5:0], 1'b0};
    end
    if (ls.bitcnt == 3'h7) begin
      next_ls.rx_byte = {ls.rx_shift, link_mosi};
      next_ls.rx_tgl  = ~ls.rx_tgl;
    end
  end

  // reset only lands while the host keeps the link clock running
  always_ff @(posedge link_sclk) begin
    if (ls.rst_sync[1]) begin
      ls <= '0;
      ls.rst_sync <= next_ls.rst_sync;
    end else begin
      ls <= next_ls;
    end
  end

  assign link_miso = ls.miso;

endmodule

// >>> verilog/tsqr_pkg.sv
// tsqr_pkg: command codes, field positions, limits and state types of the
// touch status query responder.
// assumes a 64-key 8x8 matrix; key = row + 8 * column.
package tsqr_pkg;

  // command codes
  localparam logic [7:0] CMD_STATUS     = 8'h37;
  localparam logic [7:0] CMD_GRP_SIGNAL = 8'h20;
  localparam logic [7:0] CMD_GRP_DELTA  = 8'h21;
  localparam logic [7:0] CMD_GRP_REF    = 8'h22;
  localparam logic [7:0] CMD_GRP_OFFSET = 8'h23;
  localparam logic [7:0] CMD_GRP_CANCEL = 8'h24;
  localparam logic [7:0] CMD_GRP_INTEG  = 8'h25;
  localparam logic [7:0] CMD_KEY_ERR    = 8'h65;
  localparam logic [7:0] CMD_GRP_ERR    = 8'h45;
  localparam logic [7:0] CMD_FIRST_KEY  = 8'h6b;
  localparam logic [7:0] CMD_GRP_TOUCH  = 8'h4b;
  localparam logic [7:0] CMD_SCOPE_KEY  = 8'h73;
  localparam logic [7:0] CMD_SCOPE_ALL  = 8'h53;
  localparam logic [7:0] CMD_SCOPE_ROW  = 8'h78;
  localparam logic [7:0] CMD_SCOPE_COL  = 8'h79;

  // device_status_summary bit positions
  localparam int ST_DETECT   = 0;
  localparam int ST_RECAL    = 1;
  localparam int ST_ERROR    = 2;
  localparam int ST_SYNCLOST = 3;
  localparam int ST_MISMATCH = 4;

  // key_error_flags bit positions
  localparam int ERR_FAIL  = 0;
  localparam int ERR_RECAL = 1;
  localparam int ERR_HIGH  = 2;
  localparam int ERR_LOW   = 3;

  // first-touched-key answer
  localparam int         FIRST_MORE_BIT = 7;
  localparam logic [7:0] FIRST_NONE     = 8'hff;

  // reference drift bounds and calibration retries
  localparam logic [7:0] DRIFT_HIGH_LIMIT = 8'hbf;
  localparam logic [7:0] DRIFT_LOW_LIMIT  = 8'h40;
  localparam logic [2:0] CAL_TRIES        = 3'h5;

  // response lengths in bytes
  localparam logic [6:0] LEN_ONE    = 7'h01;
  localparam logic [6:0] LEN_LINE   = 7'h08;
  localparam logic [6:0] LEN_MATRIX = 7'h40;

  // reset values
  localparam logic [7:0] IDLE_BYTE = 8'h00;
  localparam logic [2:0] LINE_RST  = 3'h0;

  typedef enum logic [2:0] {
    sc_none = 3'b000,
    sc_key  = 3'b001,
    sc_row  = 3'b010,
    sc_col  = 3'b011,
    sc_all  = 3'b100
  } tsqr_scope_e;

  typedef enum logic [3:0] {
    rk_none   = 4'b0000,
    rk_signal = 4'b0001,
    rk_delta  = 4'b0010,
    rk_ref    = 4'b0011,
    rk_offset = 4'b0100,
    rk_cancel = 4'b0101,
    rk_integ  = 4'b0110,
    rk_gerr   = 4'b0111,
    rk_touch  = 4'b1000
  } tsqr_kind_e;

  typedef enum logic {
    cal_idle = 1'b0,
    cal_wait = 1'b1
  } tsqr_cal_e;

  typedef struct packed {
    tsqr_scope_e scope;
    logic [2:0]  row;
    logic [2:0]  col;
    logic        arg_wait;
    logic [7:0]  arg_cmd;
    tsqr_kind_e  kind;
    logic [6:0]  owed;
    logic [5:0]  idx;
    logic [7:0]  tx_word;
    logic [1:0]  rx_sync;
    logic        rx_seen;
    logic [63:0] fail;
    logic [63:0] recal;
    logic [63:0] high;
    logic [63:0] low;
    tsqr_cal_e   cal;
    logic [5:0]  cal_key;
    logic [2:0]  tries;
    logic        cal_attempt;
    logic [5:0]  first_key;
    logic        first_valid;
  } tsqr_core_s;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [2:0] bitcnt;
    logic [6:0] rx_shift;
    logic [7:0] rx_byte;
    logic       rx_tgl;
    logic [6:0] tx_shift;
    logic       miso;
  } tsqr_link_s;

endpackage

// >>> verif/tsqr_responder_props.sv
// tsqr_responder_props: checks of the forced recalibration handshake.
// assumes one cal_attempt_done pulse per attempt, engine idle at reset.
`timescale 1ns/1ps
module tsqr_responder_props (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       sys_rst,
  // recalibration
  input wire logic       cal_request,
  input wire logic [5:0] cal_request_key,
  input wire logic       cal_attempt_done,
  input wire logic       cal_attempt_ok,
  input wire logic       cal_attempt,
  input wire logic [5:0] cal_attempt_key
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // engine state as seen from the ports
  logic       busy;
  logic [2:0] tries;
  wire        start = cal_request && !busy;
  wire        fail  = busy && cal_attempt_done && !cal_attempt_ok;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy  <= 1'b0;
      tries <= 3'h0;
    end else if (start) begin
      busy  <= 1'b1;
      tries <= 3'h0;
    end else begin
      if (cal_attempt) tries <= tries + 3'h1;
      if (cal_attempt_done && (cal_attempt_ok || tries == 3'h5)) busy <= 1'b0;
    end
  end
  chk_start_attempt: assert property (
    start |=> cal_attempt && cal_attempt_key == $past(cal_request_key))
    else $error("no attempt after accepted request");
  chk_attempt_pulse: assert property (
    cal_attempt |=> !cal_attempt) else $error("attempt longer than a cycle");
  chk_retry_fail: assert property (
    fail && tries < 3'h5 |=> cal_attempt) else $error("no retry after fail");
  chk_five_max: assert property (
    fail && tries == 3'h5 |=> (!cal_attempt) [*4])
    else $error("attempt after fifth failure");
  chk_ok_stops: assert property (
    busy && cal_attempt_done && cal_attempt_ok |=> (!cal_attempt) [*3])
    else $error("attempt after success");
  chk_key_holds: assert property (
    !start |=> $stable(cal_attempt_key)) else $error("attempt key moved");
  chk_attempt_cause: assert property (
    cal_attempt |-> $past(start) || $past(fail))
    else $error("attempt without cause");
  chk_reset_quiet: assert property (
    $fell(sys_rst) |-> !cal_attempt && cal_attempt_key == 6'h00)
    else $error("recalibration outputs not idle after reset");
endmodule

bind tsqr_responder tsqr_responder_props u_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .cal_request(cal_request),
  .cal_request_key(cal_request_key), .cal_attempt_done(cal_attempt_done),
  .cal_attempt_ok(cal_attempt_ok), .cal_attempt(cal_attempt),
  .cal_attempt_key(cal_attempt_key));

// >>> verif/tsqr_host_model.sv
// tsqr_host_model: host end of the serial link, byte transfers on demand.
// assumes the device samples on the rise; the link clock idles low.
`timescale 1ns/1ps
module tsqr_host_model (
  // serial link
  output logic      link_sclk,
  output logic      link_mosi,
  input  wire logic link_miso
);
  initial begin
    link_sclk = 1'b0;
    link_mosi = 1'b1;
  end
  // one byte each way, msb first, 160 ns period, miso read on the fall
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      link_mosi = tx[i];
      #80 link_sclk = 1'b1;
      #80 link_sclk = 1'b0;
      rx[i] = link_miso;
    end
    // released line shows no stale level
    link_mosi = ~tx[0];
    #160;
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      #80 link_sclk = 1'b1;
      #80 link_sclk = 1'b0;
    end
  endtask
endmodule

// >>> verif/tsqr_responder_bench.sv
// tsqr_responder_bench: queries the responder through the host model and
// compares each response byte with a behavioural model.
// assumes key inputs stay still while a query runs.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tsqr_responder_bench;
  logic         core_clk = 1'b0;
  logic         sys_rst = 1'b1;
  wire logic    link_sclk, link_mosi, link_miso;
  logic [63:0]  det, fl, rc, hi, lo;
  logic [511:0] sig, refv, offs, integ;
  logic [127:0] cz;
  logic         mode, lock, mis, creq, cdone, cok, att;
  logic [5:0]   ckey, akey;
  logic [7:0]   up, lowl, rx;
  logic [2:0]   rr, cc;
  logic [31:0]  seed = 32'he11b493b;
  int           sc, mismatches, checks;
  logic [7:0]   cmds [8] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
                             8'h45, 8'h4b};

  always #2.5 core_clk = ~core_clk;

  tsqr_responder dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .link_sclk(link_sclk), .link_mosi(link_mosi), .link_miso(link_miso),
    .key_detect(det), .key_signal(sig), .key_reference(refv),
    .key_ladder_offset(offs), .key_charge_cancel(cz), .key_integrator(integ),
    .ext_sync_mode(mode), .ext_sync_locked(lock), .setup_copy_mismatch(mis),
    .cal_request(creq), .cal_request_key(ckey), .cal_upper_limit(up),
    .cal_lower_limit(lowl), .cal_attempt_done(cdone), .cal_attempt_ok(cok),
    .cal_attempt(att), .cal_attempt_key(akey));
  tsqr_host_model host (.link_sclk(link_sclk), .link_mosi(link_mosi),
    .link_miso(link_miso));

  // drift flags stick until that key is recalibrated again
  always @(posedge core_clk) begin
    if (sys_rst) {fl, rc, hi, lo} = 256'h0;
    else for (int k = 0; k < 64; k++) if (!rc[k]) begin
      if (refv[8*k+:8] > 8'hbf) hi[k] = 1'b1;
      if (refv[8*k+:8] < 8'h40) lo[k] = 1'b1;
    end
  end

  function automatic logic [31:0] nx();
    seed = {seed[30:0], ^(seed & 32'h80200003)};
    return seed;
  endfunction

  function automatic logic [7:0] ev(input logic [7:0] c, input int i);
    int k, kk;
    logic [63:0] m;
    logic [7:0] ke;
    k = (sc == 1) ? rr + 8 * i : (sc == 2) ? i + 8 * cc : i;
    kk = rr + 8 * cc;
    m = (c == 8'h45) ? (fl | hi | lo) : det;
    ke = {4'h0, lo[kk], hi[kk], rc[kk], fl[kk]};
    case (c)
      8'h37: ev = {3'h0, mis, mode & ~lock, |(fl | hi | lo), |rc, |det};
      8'h20: ev = sig[8*k+:8];
      8'h21: ev = (refv[8*k+:8] > sig[8*k+:8]) ?
                  refv[8*k+:8] - sig[8*k+:8] : 8'h00;
      8'h22: ev = refv[8*k+:8];
      8'h23: ev = offs[8*k+:8];
      8'h24: ev = {6'h00, cz[2*k+:2]};
      8'h25: ev = integ[8*k+:8];
      8'h65: ev = ke;
      8'h6b: ev = 8'hff;
      default: begin
        for (int n = 0; n < 8; n++)
          ev[n] = (sc == 1) ? m[rr + 8 * n] : (sc == 2) ? m[n + 8 * cc]
                : m[n + 8 * i];
        if (sc == 3) ev = (c == 8'h45) ? ke : {7'h00, det[kk]};
      end
    endcase
  endfunction

  function automatic int len(input logic [7:0] c);
    if (c >= 8'h20 && c <= 8'h25) return (sc == 1 || sc == 2) ? 8 : 64;
    if (c == 8'h45 || c == 8'h4b) return (sc == 0) ? 8 : 1;
    return 1;
  endfunction

  task automatic qry(input logic [7:0] c);
    host.xfer(c, rx);
    for (int i = 0; i < len(c); i++) begin
      host.xfer(8'h00, rx);
      `CHK(rx, ev(c, i))
    end
  endtask

  task automatic scope(input logic [7:0] c, input logic [7:0] a);
    host.xfer(c, rx);
    if (c != 8'h53) host.xfer(a, rx);
    host.xfer(8'h00, rx);
    `CHK(rx, c)
    sc = (c == 8'h73) ? 3 : (c == 8'h78) ? 1 : (c == 8'h79) ? 2 : 0;
    if (c == 8'h73) {cc, rr} = a[5:0];
    if (c == 8'h78) rr = a[2:0];
    if (c == 8'h79) cc = a[2:0];
  endtask

  task automatic fk(input logic [63:0] d, input logic [5:0] gone);
    @(posedge core_clk) det <= d;
    host.xfer(8'h6b, rx);
    host.xfer(8'h00, rx);
    `CHK({rx[7:6], det[rx[5:0]], rx[5:0] != gone}, 4'hb)
  endtask

  task automatic rnd();
    @(posedge core_clk);
    for (int i = 0; i < 16; i++) begin
      sig[32*i+:32] <= nx();
      refv[32*i+:32] <= nx();
      offs[32*i+:32] <= nx();
      integ[32*i+:32] <= nx();
    end
    cz <= {nx(), nx(), nx(), nx()};
    det <= {nx(), nx()};
  endtask

  task automatic cal(input logic [5:0] k, input int nf);
    @(posedge core_clk);
    creq <= 1'b1;
    ckey <= k;
    @(posedge core_clk);
    creq <= 1'b0;
    {rc[k], hi[k], lo[k], fl[k]} = 4'h8;
    for (int a = 0; a < 5; a++) begin
      for (int w = 0; w < 20 && att !== 1'b1; w++) @(negedge core_clk);
      `CHK({att, akey}, {1'b1, k})
      @(posedge core_clk);
      cdone <= 1'b1;
      cok <= (a >= nf);
      @(posedge core_clk);
      cdone <= 1'b0;
      if (a >= nf) break;
    end
    rc[k] = 1'b0;
    if (nf >= 5) fl[k] = 1'b1;
    else {hi[k], lo[k]} = {refv[8*k+:8] > up, refv[8*k+:8] < lowl};
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    {det, sig, offs, integ, cz} = '0;
    refv = {64{8'h80}};
    {mode, lock, mis, creq, cdone, cok} = 6'h10;
    {ckey, up, lowl, rr, cc, sc} = {6'h00, 8'hff, 8'h00, 3'h0, 3'h0, 32'h0};
    // link side needs its own edges to leave reset
    repeat (3) @(posedge core_clk);
    host.pulses(3);
    @(posedge core_clk) sys_rst <= 1'b0;
    host.pulses(2);
    qry(8'h37);
    qry(8'h6b);
    qry(8'h4b);
    fk(64'h0000_0100_0000_0020, 6'h3f);
    fk(64'h0000_0100_0000_0008, 6'h05);
    rnd();
    for (int j = 0; j < 8; j++) begin
      @(posedge core_clk) {mode, lock, mis} <= j[2:0];
      qry(8'h37);
    end
    @(posedge core_clk) {refv[79:72], refv[87:80]} <= 16'hc845;
    {up, lowl} <= 16'ha050;
    repeat (4) @(posedge core_clk);
    refv[79:72] <= 8'hb0;
    cal(6'h09, 5);
    scope(8'h73, 8'hc9);
    qry(8'h65);
    qry(8'h45);
    qry(8'h37);
    cal(6'h09, 2);
    qry(8'h65);
    cal(6'h0a, 0);
    scope(8'h73, 8'h0a);
    qry(8'h65);
    rnd();
    scope(8'h78, 8'hfb);
    foreach (cmds[i]) qry(cmds[i]);
    scope(8'h79, 8'hfd);
    qry(8'h45);
    qry(8'h4b);
    qry(8'h24);
    scope(8'h53, 8'h00);
    qry(8'h21);
    qry(8'h45);
    qry(8'h4b);
    give_verdict();
  end

  // about 200 bytes at 1.44 us each, with margin
  initial begin
    #400000;
    mismatches++;
    give_verdict();
  end
endmodule
